// *** pkg/jtag_decode_pkg.sv ***
/*
 * Shared constants for the test access port: instruction codes, chain
 * lengths, boundary cell layout and the tap state and chain encodings.
 * Assumes nothing of its surroundings.
 */
package jtag_decode_pkg;

    localparam int IR_WIDTH = 4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_EXTEST = 4'h0;
    localparam logic [3:0] IR_INTEST = 4'h1;
    localparam logic [3:0] IR_SAMPLE = 4'h2;
    localparam logic [3:0] IR_ABORT = 4'h8;
    localparam logic [3:0] IR_DEBUG_PORT_ACCESS_CHAIN = 4'ha;
    localparam logic [3:0] IR_ACCESS_PORT_ACCESS_CHAIN = 4'hb;
    localparam logic [3:0] IR_IDCODE = 4'he;
    localparam logic [3:0] IR_BYPASS = 4'hf;

    localparam int ID_LEN = 32;
    // identification value is arbitrary; bit 0 must stay 1
    localparam logic [31:0] IDCODE_VALUE = 32'h0000_1001;
    localparam logic BYPASS_CAPTURE = 1'h0;

    localparam int GPIO_COUNT = 8;
    localparam int CELLS_PER_PIN = 3;
    localparam int BS_IN = 0;
    localparam int BS_OUT = 1;
    localparam int BS_OE = 2;
    localparam int BS_RST_POS = GPIO_COUNT * CELLS_PER_PIN;
    localparam int BS_LEN = BS_RST_POS + 1;

    localparam int DBG_LEN = 35;
    localparam logic [34:0] ABORT_CAPTURE = 35'h0;

    typedef enum logic [3:0] {
        ST_EX2_DR = 4'h0, ST_EX1_DR = 4'h1, ST_SH_DR = 4'h2,
        ST_PAU_DR = 4'h3, ST_SEL_IR = 4'h4, ST_UPD_DR = 4'h5,
        ST_CAP_DR = 4'h6, ST_SEL_DR = 4'h7, ST_EX2_IR = 4'h8,
        ST_EX1_IR = 4'h9, ST_SH_IR = 4'ha, ST_PAU_IR = 4'hb,
        ST_RTI = 4'hc, ST_UPD_IR = 4'hd, ST_CAP_IR = 4'he,
        ST_TLR = 4'hf
    } tap_state_t;

    typedef enum logic [2:0] {
        DR_BYPASS = 3'h0, DR_IDCODE = 3'h1, DR_BOUNDARY = 3'h2,
        DR_ABORT = 3'h3, DR_DEBUG_PORT_ACCESS_CHAIN = 3'h4, DR_ACCESS_PORT_ACCESS_CHAIN = 3'h5
    } dr_sel_t;

endpackage

// *** core/jtag_debug_chain.sv ***
/*
 * One 35-bit debug access chain: shift stage on the test clock, a
 * holding word, and a toggle handshake that hands each update to the
 * system clock as a word plus a one-cycle strobe.
 * Assumes the capture word is held stable while a capture can occur.
 */
`timescale 1ns/1ps
`default_nettype none
module jtag_debug_chain
    import jtag_decode_pkg::*;
(
    input wire logic tck,
    input wire logic tap_rst,
    input wire logic sel,
    input wire logic cap,
    input wire logic shift,
    input wire logic upd,
    input wire logic tdi,
    input wire logic [DBG_LEN-1:0] capture_word,
    output logic tdo_bit,
    input wire logic sys_clk,
    input wire logic sys_rst,
    output logic [DBG_LEN-1:0] word,
    output logic strobe
);
    logic [DBG_LEN-1:0] cap_s1_reg, cap_s2_reg, shift_reg, hold_reg;
    logic [DBG_LEN-1:0] word_reg;
    logic toggle_reg, tg_s1_reg, tg_s2_reg, tg_s3_reg, strobe_reg;
    wire pulse;

    // ----------------------------------------
    // test clock side
    // ----------------------------------------
    always_ff @(posedge tck) begin
        if (tap_rst) begin
            cap_s1_reg <= '0;
            cap_s2_reg <= '0;
            shift_reg <= '0;
            hold_reg <= '0;
            toggle_reg <= 1'h0;
        end else begin
            cap_s1_reg <= capture_word;
            cap_s2_reg <= cap_s1_reg;
            if (sel && cap)
                shift_reg <= cap_s2_reg;
            else if (sel && shift)
                shift_reg <= {tdi, shift_reg[DBG_LEN-1:1]}; // see [R7]
            if (sel && upd) begin
                hold_reg <= shift_reg; // see [R6]
                toggle_reg <= ~toggle_reg;
            end
        end
    end
    assign tdo_bit = shift_reg[0];

    // ----------------------------------------
    // system clock side
    // ----------------------------------------
    // hold_reg is stable long before the toggle is seen here
    assign pulse = tg_s2_reg ^ tg_s3_reg;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tg_s1_reg <= 1'h0;
            tg_s2_reg <= 1'h0;
            tg_s3_reg <= 1'h0;
            word_reg <= '0;
            strobe_reg <= 1'h0;
        end else begin
            tg_s1_reg <= toggle_reg;
            tg_s2_reg <= tg_s1_reg;
            tg_s3_reg <= tg_s2_reg;
            strobe_reg <= pulse;
            if (pulse)
                word_reg <= hold_reg; // see [R19]
        end
    end
    assign word = word_reg;
    assign strobe = strobe_reg;

    a_update_handoff: assert property ( // see [R19]
        @(posedge tck) disable iff (tap_rst)
        sel && upd |=> toggle_reg != $past(toggle_reg)
            && hold_reg == $past(shift_reg))
        else $error("debug chain update not handed over");

    a_strobe_word: assert property ( // see [R6]
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(tg_s2_reg) or $fell(tg_s2_reg) |=> strobe_reg ##1 !strobe_reg)
        else $error("debug chain strobe not one cycle");

endmodule
`default_nettype wire

// *** core/jtag_instruction_decode.sv ***
/*
 * Test access port: state machine, 4-bit instruction register and
 * decode, identification, bypass and boundary chains, debug chains,
 * and the boundary override of the pads and core inputs.
 * Assumes the prober drives TMS and TDI from the TCK it supplies and
 * leaves several system clocks between two updates of one chain.
 */
// How it works
// [R1] four-bit instruction shift chain with holding register
// [R2] new instruction takes effect only at update
// [R3] code 0000 drives preload onto pads
// [R4] code 0001 drives preload into core
// [R5] code 0010 samples pads, shifts, preloads
// [R6] code 1000 selects the abort chain
// [R7] code 1010 selects debug port access chain
// [R8] code 1011 selects access port access chain
// [R9] code 1110 shifts out the identification value
// [R10] code 1111 uses one-stage bypass path
// [R11] unlisted codes behave exactly like bypass
// [R12] pad override uses preloaded output and enable
// [R13] boundary chain stays reachable in override modes
// [R14] core inputs override uses preloaded input bits
// [R15] reset pin is observed, never overridden
// [R16] capture samples input, output, enable per pad
// [R17] shift captured bits out while new shift in
// [R18] update copies boundary chain into holding word
// [R19] abort value shifted in is acted on
// [R20] identification loaded on reset and idle reset
// [R21] bypass is exactly one stage long
// [R22] six selectable data chains in total
// [R23] identification is 32 bits, bit 0 one
// [R24] bypass captures zero
// [R25] three cells per pin: in, out, enable
// [R26] the three debug chains are 35 bits
// [R27] standard sixteen-state controller, tdo on falling
`timescale 1ns/1ps
`default_nettype none
module jtag_instruction_decode
    import jtag_decode_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic TRST_N,
    output logic TDO,
    output logic TDO_OE,
    input wire logic [GPIO_COUNT-1:0] GPIO_IN,
    output logic [GPIO_COUNT-1:0] GPIO_OUT,
    output logic [GPIO_COUNT-1:0] GPIO_OE,
    input wire logic [GPIO_COUNT-1:0] CORE_OUT,
    input wire logic [GPIO_COUNT-1:0] CORE_OE,
    output logic [GPIO_COUNT-1:0] CORE_IN,
    input wire logic EXT_RST_N,
    output logic CORE_RST_N,
    input wire logic [DBG_LEN-1:0] DP_RESULT,
    input wire logic [DBG_LEN-1:0] AP_RESULT,
    output logic [DBG_LEN-1:0] ABORT_WORD,
    output logic ABORT_STB,
    output logic [DBG_LEN-1:0] DP_WORD,
    output logic DP_STB,
    output logic [DBG_LEN-1:0] AP_WORD,
    output logic AP_STB
);
    // ----------------------------------------
    // test clock reset
    // ----------------------------------------
    logic por_s1_reg, por_s2_reg;
    logic trst_s1_reg, trst_s2_reg, trst_s3_reg;
    wire tap_rst;

    // power-on reset reaches the port only while TCK runs
    always_ff @(posedge TCK) begin
        por_s1_reg <= RST;
        por_s2_reg <= por_s1_reg;
        trst_s1_reg <= TRST_N;
        trst_s2_reg <= trst_s1_reg;
        trst_s3_reg <= trst_s2_reg;
    end
    assign tap_rst = por_s2_reg | (~trst_s2_reg & ~trst_s3_reg);

    // ----------------------------------------
    // tap state machine
    // ----------------------------------------
    tap_state_t state_reg, state_next;

    always_comb begin
        case (state_reg)
            ST_TLR: state_next = TMS ? ST_TLR : ST_RTI;
            ST_RTI: state_next = TMS ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_next = TMS ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = TMS ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_next = TMS ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = TMS ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_next = TMS ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_next = TMS ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_next = TMS ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_next = TMS ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_next = TMS ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_next = TMS ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_next = TMS ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_next = TMS ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_next = TMS ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_next = TMS ? ST_SEL_DR : ST_RTI;
            default: state_next = ST_TLR;
        endcase
    end

    always_ff @(posedge TCK) begin
        if (tap_rst)
            state_reg <= ST_TLR;
        else
            state_reg <= state_next; // see [R27]
    end

    wire in_tlr, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir;
    assign in_tlr = state_reg == ST_TLR;
    assign cap_dr = state_reg == ST_CAP_DR;
    assign sh_dr = state_reg == ST_SH_DR;
    assign upd_dr = state_reg == ST_UPD_DR;
    assign cap_ir = state_reg == ST_CAP_IR;
    assign sh_ir = state_reg == ST_SH_IR;
    assign upd_ir = state_reg == ST_UPD_IR;

    // ----------------------------------------
    // instruction register and decode
    // ----------------------------------------
    logic [IR_WIDTH-1:0] ir_shift_reg, ir_reg;
    logic mode_ext_reg, mode_int_reg;

    always_ff @(posedge TCK) begin
        if (tap_rst || cap_ir)
            ir_shift_reg <= IR_CAPTURE;
        else if (sh_ir)
            ir_shift_reg <= {TDI, ir_shift_reg[IR_WIDTH-1:1]}; // see [R1]
        if (tap_rst || in_tlr)
            ir_reg <= IR_IDCODE; // see [R20]
        else if (upd_ir)
            ir_reg <= ir_shift_reg; // see [R2]
        // modes follow the update edge itself: tck may stop right after it
        if (tap_rst || in_tlr || upd_ir) begin
            mode_ext_reg <= upd_ir && ir_shift_reg == IR_EXTEST; // see [R3]
            mode_int_reg <= upd_ir && ir_shift_reg == IR_INTEST; // see [R4]
        end
    end

    wire sel_bs;
    dr_sel_t dr_sel;
    // boundary stays selected in both override modes; see [R13]
    assign sel_bs = ir_reg == IR_EXTEST || ir_reg == IR_INTEST
        || ir_reg == IR_SAMPLE; // see [R5]
    // anything unlisted falls through to bypass; see [R11] [R22]
    assign dr_sel = sel_bs ? DR_BOUNDARY
        : ir_reg == IR_ABORT ? DR_ABORT
        : ir_reg == IR_DEBUG_PORT_ACCESS_CHAIN ? DR_DEBUG_PORT_ACCESS_CHAIN
        : ir_reg == IR_ACCESS_PORT_ACCESS_CHAIN ? DR_ACCESS_PORT_ACCESS_CHAIN
        : ir_reg == IR_IDCODE ? DR_IDCODE : DR_BYPASS;

    // ----------------------------------------
    // bypass, identification and boundary chains
    // ----------------------------------------
    logic bypass_reg;
    logic [ID_LEN-1:0] id_shift_reg;
    logic [BS_LEN-1:0] bs_shift_reg, bs_hold_reg;
    logic [BS_LEN-1:0] obs_reg, obs_s1_reg, obs_s2_reg;
    logic bs_toggle_reg;

    always_ff @(posedge TCK) begin
        if (tap_rst || (cap_dr && dr_sel == DR_BYPASS))
            bypass_reg <= BYPASS_CAPTURE; // see [R24]
        else if (sh_dr && dr_sel == DR_BYPASS)
            bypass_reg <= TDI; // see [R10] [R21]
        if (tap_rst || (cap_dr && dr_sel == DR_IDCODE))
            id_shift_reg <= IDCODE_VALUE; // see [R9] [R23]
        else if (sh_dr && dr_sel == DR_IDCODE)
            id_shift_reg <= {TDI, id_shift_reg[ID_LEN-1:1]};
    end

    always_ff @(posedge TCK) begin
        if (tap_rst) begin
            obs_s1_reg <= '0;
            obs_s2_reg <= '0;
            bs_shift_reg <= '0;
            bs_hold_reg <= '0;
            bs_toggle_reg <= 1'h0;
        end else begin
            obs_s1_reg <= obs_reg;
            obs_s2_reg <= obs_s1_reg;
            if (cap_dr && sel_bs)
                bs_shift_reg <= obs_s2_reg; // see [R16]
            else if (sh_dr && sel_bs)
                bs_shift_reg <= {TDI, bs_shift_reg[BS_LEN-1:1]}; // see [R17]
            if (upd_dr && sel_bs) begin
                bs_hold_reg <= bs_shift_reg; // see [R18]
                bs_toggle_reg <= ~bs_toggle_reg;
            end
        end
    end

    // ----------------------------------------
    // debug access chains
    // ----------------------------------------
    wire abort_tdo, dp_tdo, ap_tdo;

    jtag_debug_chain u_abort (
        .tck(TCK), .tap_rst(tap_rst), .sel(dr_sel == DR_ABORT),
        .cap(cap_dr), .shift(sh_dr), .upd(upd_dr), .tdi(TDI),
        .capture_word(ABORT_CAPTURE), .tdo_bit(abort_tdo),
        .sys_clk(SYS_CLK), .sys_rst(RST),
        .word(ABORT_WORD), .strobe(ABORT_STB)
    ); // see [R6] [R19] [R26]

    jtag_debug_chain u_debug_port_access_chain (
        .tck(TCK), .tap_rst(tap_rst), .sel(dr_sel == DR_DEBUG_PORT_ACCESS_CHAIN),
        .cap(cap_dr), .shift(sh_dr), .upd(upd_dr), .tdi(TDI),
        .capture_word(DP_RESULT), .tdo_bit(dp_tdo),
        .sys_clk(SYS_CLK), .sys_rst(RST),
        .word(DP_WORD), .strobe(DP_STB)
    ); // see [R7] [R26]

    jtag_debug_chain u_access_port_access_chain (
        .tck(TCK), .tap_rst(tap_rst), .sel(dr_sel == DR_ACCESS_PORT_ACCESS_CHAIN),
        .cap(cap_dr), .shift(sh_dr), .upd(upd_dr), .tdi(TDI),
        .capture_word(AP_RESULT), .tdo_bit(ap_tdo),
        .sys_clk(SYS_CLK), .sys_rst(RST),
        .word(AP_WORD), .strobe(AP_STB)
    ); // see [R8] [R26]

    // ----------------------------------------
    // serial output, changes on the falling edge
    // ----------------------------------------
    wire dr_tdo;
    logic tdo_reg, tdo_oe_reg;

    assign dr_tdo = dr_sel == DR_BOUNDARY ? bs_shift_reg[0]
        : dr_sel == DR_ABORT ? abort_tdo
        : dr_sel == DR_DEBUG_PORT_ACCESS_CHAIN ? dp_tdo
        : dr_sel == DR_ACCESS_PORT_ACCESS_CHAIN ? ap_tdo
        : dr_sel == DR_IDCODE ? id_shift_reg[0] : bypass_reg;

    always_ff @(negedge TCK) begin
        if (tap_rst) begin
            tdo_reg <= 1'h0;
            tdo_oe_reg <= 1'h0;
        end else begin
            tdo_oe_reg <= sh_ir | sh_dr;
            if (sh_ir)
                tdo_reg <= ir_shift_reg[0]; // see [R27]
            else if (sh_dr)
                tdo_reg <= dr_tdo;
        end
    end
    assign TDO = tdo_reg;
    assign TDO_OE = tdo_oe_reg;

    // ----------------------------------------
    // system side: pin filters and pad override
    // ----------------------------------------
    logic [GPIO_COUNT-1:0] gin_s1_reg, gin_s2_reg, gin_s3_reg, gin_val_reg;
    logic [GPIO_COUNT-1:0] gpio_out_reg, gpio_oe_reg, core_in_reg;
    logic rst_s1_reg, rst_s2_reg, rst_s3_reg, rst_val_reg, core_rst_reg;
    logic ext_s1_reg, ext_s2_reg, int_s1_reg, int_s2_reg;
    logic tg_s1_reg, tg_s2_reg, tg_s3_reg;
    logic [BS_LEN-1:0] pre_reg;
    wire [GPIO_COUNT-1:0] gin_val_next, pre_in, pre_out, pre_oe;
    wire [BS_LEN-1:0] obs_next;
    wire bs_pulse;

    // a pin change counts only once the last two stages agree
    assign gin_val_next = (gin_s2_reg & ~(gin_s2_reg ^ gin_s3_reg))
        | (gin_val_reg & (gin_s2_reg ^ gin_s3_reg));
    assign bs_pulse = tg_s2_reg ^ tg_s3_reg;

    genvar i;
    generate
        for (i = 0; i < GPIO_COUNT; i = i + 1) begin : g_pin
            // see [R25]
            assign pre_in[i] = pre_reg[i*CELLS_PER_PIN+BS_IN];
            assign pre_out[i] = pre_reg[i*CELLS_PER_PIN+BS_OUT];
            assign pre_oe[i] = pre_reg[i*CELLS_PER_PIN+BS_OE];
            assign obs_next[i*CELLS_PER_PIN+BS_IN] = gin_val_reg[i];
            assign obs_next[i*CELLS_PER_PIN+BS_OUT] = gpio_out_reg[i];
            assign obs_next[i*CELLS_PER_PIN+BS_OE] = gpio_oe_reg[i];
        end
    endgenerate
    assign obs_next[BS_RST_POS] = rst_val_reg; // see [R15]

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            gin_s1_reg <= '0;
            gin_s2_reg <= '0;
            gin_s3_reg <= '0;
            gin_val_reg <= '0;
            rst_s1_reg <= 1'h0;
            rst_s2_reg <= 1'h0;
            rst_s3_reg <= 1'h0;
            rst_val_reg <= 1'h0;
            ext_s1_reg <= 1'h0;
            ext_s2_reg <= 1'h0;
            int_s1_reg <= 1'h0;
            int_s2_reg <= 1'h0;
            tg_s1_reg <= 1'h0;
            tg_s2_reg <= 1'h0;
            tg_s3_reg <= 1'h0;
            pre_reg <= '0;
            obs_reg <= '0;
        end else begin
            gin_s1_reg <= GPIO_IN;
            gin_s2_reg <= gin_s1_reg;
            gin_s3_reg <= gin_s2_reg;
            gin_val_reg <= gin_val_next;
            rst_s1_reg <= EXT_RST_N;
            rst_s2_reg <= rst_s1_reg;
            rst_s3_reg <= rst_s2_reg;
            if (rst_s2_reg == rst_s3_reg)
                rst_val_reg <= rst_s3_reg;
            ext_s1_reg <= mode_ext_reg;
            ext_s2_reg <= ext_s1_reg;
            int_s1_reg <= mode_int_reg;
            int_s2_reg <= int_s1_reg;
            tg_s1_reg <= bs_toggle_reg;
            tg_s2_reg <= tg_s1_reg;
            tg_s3_reg <= tg_s2_reg;
            if (bs_pulse)
                pre_reg <= bs_hold_reg;
            obs_reg <= obs_next;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            gpio_out_reg <= '0;
            gpio_oe_reg <= '0;
            core_in_reg <= '0;
            core_rst_reg <= 1'h0;
        end else begin
            gpio_out_reg <= ext_s2_reg ? pre_out : CORE_OUT; // see [R12]
            gpio_oe_reg <= ext_s2_reg ? pre_oe : CORE_OE;
            core_in_reg <= int_s2_reg ? pre_in : gin_val_reg; // see [R14]
            core_rst_reg <= rst_val_reg; // see [R15]
        end
    end
    assign GPIO_OUT = gpio_out_reg;
    assign GPIO_OE = gpio_oe_reg;
    assign CORE_IN = core_in_reg;
    assign CORE_RST_N = core_rst_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_idle_reset_id: assert property ( // see [R20]
        @(posedge TCK) disable iff (tap_rst)
        in_tlr |=> ir_reg == IR_IDCODE)
        else $error("idle reset did not load identification");

    a_ir_holds: assert property ( // see [R2]
        @(posedge TCK) disable iff (tap_rst)
        !upd_ir && !in_tlr |=> $stable(ir_reg))
        else $error("instruction changed without update");

    a_ir_update: assert property ( // see [R1]
        @(posedge TCK) disable iff (tap_rst)
        sh_ir ##1 upd_ir |=> ir_reg == $past(ir_shift_reg))
        else $error("instruction update lost shifted bits");

    a_bypass_zero: assert property ( // see [R24]
        @(posedge TCK) disable iff (tap_rst)
        cap_dr && dr_sel == DR_BYPASS |=> bypass_reg == 1'h0)
        else $error("bypass did not capture zero");

    a_id_capture: assert property ( // see [R23]
        @(posedge TCK) disable iff (tap_rst)
        cap_dr && dr_sel == DR_IDCODE
            |=> id_shift_reg[0] == 1'h1 && id_shift_reg == IDCODE_VALUE)
        else $error("identification capture wrong");

    a_reserved_bypass: assert property ( // see [R11]
        @(posedge TCK) disable iff (tap_rst)
        ir_reg inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd}
            && sh_dr |=> bypass_reg == $past(TDI))
        else $error("reserved code did not bypass");

    a_bs_shift: assert property ( // see [R17]
        @(posedge TCK) disable iff (tap_rst)
        sh_dr && sel_bs |=> bs_shift_reg[BS_LEN-1] == $past(TDI)
            && bs_shift_reg[BS_LEN-2:0] == $past(bs_shift_reg[BS_LEN-1:1]))
        else $error("boundary chain did not shift");

    a_bs_update: assert property ( // see [R18]
        @(posedge TCK) disable iff (tap_rst)
        upd_dr && sel_bs |=> bs_hold_reg == $past(bs_shift_reg))
        else $error("boundary update not held");

    a_tdo_enable: assert property ( // see [R27]
        @(negedge TCK) disable iff (tap_rst)
        sh_dr |=> tdo_oe_reg)
        else $error("serial output not enabled in shift");

    a_pad_override: assert property ( // see [R12]
        @(posedge SYS_CLK) disable iff (RST)
        ext_s2_reg |=> GPIO_OUT == $past(pre_out)
            && GPIO_OE == $past(pre_oe))
        else $error("pads not driven from preload");

endmodule
`default_nettype wire

// *** sim/jtag_probe.sv ***
/* probe model for the test port: steps tck, drives tms and tdi.
   assumes the port samples tms and tdi on the rising tck. */
`timescale 1ns/1ps
`default_nettype none
module jtag_probe (
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo
);
    // ----
    // link stepping; tck rests low between frames
    // ----
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end
    task automatic hold_reset(input logic v);
        trst_n = v;
    endtask
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #16;
        q = tdo;
        tck = 1'b1;
        #16;
        tck = 1'b0;
    endtask
    // tdi toggles outside shifts so a stale bit is never read as data
    task automatic idle(input logic m);
        logic q;
        step(m, ~tdi, q);
    endtask
    task automatic scan(input logic ir, input int n,
                        input logic [63:0] d, output logic [63:0] q);
        logic b;
        q = '0;
        idle(1'b1);
        if (ir)
            idle(1'b1);
        idle(1'b0);
        idle(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        idle(1'b1);
        idle(1'b0);
    endtask
endmodule
`default_nettype wire

// *** sim/jtag_instruction_decode_tb.sv ***
/* self-checking bench for the test port decode.
   assumes the probe model drives the link side. */
`timescale 1ns/1ps
`default_nettype none
module jtag_instruction_decode_tb
    import jtag_decode_pkg::*;
;
    // ----
    // harness
    // ----
    logic sys_clk, rst, tck, tms, tdi, trst_n, tdo, core_rst_n;
    logic ext_rst_n, tdo_oe;
    logic [7:0] gpio_in, gpio_out, gpio_oe, core_out, core_oe, core_in;
    logic [34:0] dp_result, ap_result;
    logic [34:0] wd [3];
    logic [2:0] stb;
    int n_errors, samples_checked;
    jtag_instruction_decode dut_u (.SYS_CLK(sys_clk), .RST(rst),
        .TCK(tck), .TMS(tms), .TDI(tdi), .TRST_N(trst_n), .TDO(tdo),
        .TDO_OE(tdo_oe), .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out),
        .GPIO_OE(gpio_oe), .CORE_OUT(core_out), .CORE_OE(core_oe),
        .CORE_IN(core_in), .EXT_RST_N(ext_rst_n), .CORE_RST_N(core_rst_n),
        .DP_RESULT(dp_result), .AP_RESULT(ap_result),
        .ABORT_WORD(wd[0]), .ABORT_STB(stb[0]), .DP_WORD(wd[1]),
        .DP_STB(stb[1]), .AP_WORD(wd[2]), .AP_STB(stb[2]));
    jtag_probe probe_u (.tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input string s, input logic [63:0] e,
                       input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [63:0] bvec(input logic [7:0] i, o, e);
        logic [63:0] v;
        v = '0;
        for (int k = 0; k < GPIO_COUNT; k++) begin
            v[3*k+BS_IN] = i[k];
            v[3*k+BS_OUT] = o[k];
            v[3*k+BS_OE] = e[k];
        end
        v[BS_RST_POS] = 1'b1;
        return v;
    endfunction
    // ----
    // scenarios
    // ----
    task automatic load(input logic [3:0] c);
        logic [63:0] q;
        probe_u.scan(1'b1, IR_WIDTH, 64'(c), q);
        chk("ir capture", 64'(IR_CAPTURE), q);
    endtask
    task automatic t_idcode();
        logic [63:0] q;
        probe_u.scan(1'b0, ID_LEN, '0, q);
        chk("idcode", 64'(IDCODE_VALUE), q);
        chk("tdo oe idle", 64'h0, 64'(tdo_oe));
    endtask
    task automatic t_bypass();
        logic [63:0] q;
        logic [3:0] c [9];
        c = '{4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd};
        foreach (c[k]) begin
            load(c[k]);
            probe_u.scan(1'b0, 4, 64'hb, q);
            chk("bypass", 64'h6, q);
        end
    endtask
    task automatic t_debug();
        logic [63:0] q, d;
        logic [63:0] cap [3];
        logic [3:0] c [3];
        int w;
        c = '{IR_ABORT, IR_DEBUG_PORT_ACCESS_CHAIN, IR_ACCESS_PORT_ACCESS_CHAIN};
        cap = '{64'(ABORT_CAPTURE), 64'(dp_result), 64'(ap_result)};
        for (int k = 0; k < 3; k++) begin
            d = 64'h5_1234_abcd + 64'(k);
            load(c[k]);
            probe_u.scan(1'b0, DBG_LEN, d, q);
            chk("dbg capture", cap[k], q);
            w = 0;
            while (stb[k] !== 1'b1 && w < 40) begin
                @(negedge sys_clk);
                w++;
            end
            if (w == 40) begin
                n_errors++;
                complete_run();
            end
            chk("dbg word", d, 64'(wd[k]));
        end
    endtask
    task automatic t_boundary();
        logic [63:0] q, pre;
        pre = bvec(8'hc3, 8'h5a, 8'h0f) & ~(64'h1 << BS_RST_POS);
        load(IR_SAMPLE);
        probe_u.scan(1'b0, BS_LEN, pre, q);
        chk("sample", bvec(8'ha5, 8'h3c, 8'hf0), q);
        load(IR_EXTEST);
        repeat (10) @(negedge sys_clk);
        chk("pad out", 64'h5a, 64'(gpio_out));
        chk("pad oe", 64'h0f, 64'(gpio_oe));
        core_out = 8'h99;
        repeat (4) @(negedge sys_clk);
        chk("pad hold", 64'h5a, 64'(gpio_out));
        core_out = 8'h3c;
        probe_u.scan(1'b0, BS_LEN, pre, q);
        chk("extest scan", bvec(8'ha5, 8'h5a, 8'h0f), q);
        load(IR_INTEST);
        repeat (10) @(negedge sys_clk);
        chk("core in", 64'hc3, 64'(core_in));
        chk("pad back", 64'h3c, 64'(gpio_out));
        chk("core rst", 64'h1, 64'(core_rst_n));
        gpio_in = 8'h66;
        ext_rst_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        chk("core in held", 64'hc3, 64'(core_in));
        chk("core rst pin", 64'h0, 64'(core_rst_n));
        ext_rst_n = 1'b1;
        gpio_in = 8'ha5;
    endtask
    task automatic t_trst();
        load(IR_BYPASS);
        probe_u.hold_reset(1'b0);
        repeat (5) probe_u.idle(1'b0);
        probe_u.hold_reset(1'b1);
        repeat (3) probe_u.idle(1'b0);
        t_idcode();
    endtask
    initial begin
        rst = 1'b1;
        ext_rst_n = 1'b1;
        gpio_in = 8'ha5;
        core_out = 8'h3c;
        core_oe = 8'hf0;
        dp_result = 35'h3_0f0f_1234;
        ap_result = 35'h4_5555_aaaa;
        n_errors = 0;
        samples_checked = 0;
        fork
            repeat (12) @(negedge sys_clk);
            repeat (20) probe_u.idle(1'b1);
        join
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (5) probe_u.idle(1'b1);
        probe_u.idle(1'b0);
        t_idcode();
        t_bypass();
        t_debug();
        t_boundary();
        t_trst();
        complete_run();
    end
endmodule
`default_nettype wire
